// ---- uart_ext_ctrl.sv ----
// Extended control, loopback wiring, prescaler, divisor lock, levels and shadows of a serial port.
// Assumes an APB master on CORE_CLK and a transmitter/receiver core beside it.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Overview of operation
// (RULE1) Reset clears both extended control registers.
// (RULE2) Extended control one bit 0 selects extended mode.
// (RULE3) Extended control one bit 4 is loopback, shared with modem control bit 4.
// (RULE4) Extended loopback: DTR drives DSR and RI, RTS drives CTS and DCD.
// (RULE5) Loopback keeps all interrupts; modem status comes from modem control.
// (RULE6) Loopback ignores receive pins and feeds receivers from transmitters.
// (RULE7) Loopback holds wired output high, infrared low, unless tx during loopback.
// (RULE8) Loopback disconnects modem status pins, using modem control low bits.
// (RULE9) Extended control one bit 5 keeps transmitter output alive in loopback.
// (RULE10) Extended control one bit 7 routes baud generator to DTR pin.
// (RULE11) Reserved bits of both extended control registers read zero.
// (RULE12) Extended control two bits 5:4 pick prescaler 13, 1.625 or 1.
// (RULE13) Lock bit blocks legacy divisor access and fallback outside extended mode.
// (RULE14) Under lock, legacy divisor locations reach two scratch bytes.
// (RULE15) Software keeps lock zero while extended mode is selected.
// (RULE16) Bank 2 offset 5 resets to zero and reads zero.
// (RULE17) Level registers give FIFO byte counts in bits 4:0, rest zero.
// (RULE18) Level values are live and may change during a read.
// (RULE19) Software reads a level thrice and picks by agreement.
// (RULE20) Revision register holds module type high, revision level low.
// (RULE21) Line control shadow follows writes at offset 3 of any bank.
// (RULE22) FIFO control shadow returns last bank 0 FIFO control write.
// (RULE23) Offset 3 of banks 2 and 3 is the bank 0 line control.
// (RULE24) Legacy divisor access falls back to non-extended mode unless locked.
// (RULE25) Bank 2 divisor ports set the divisor without mode change.
// (RULE26) Level counters count pushes and pops, saturating in five bits.
module uart_ext_ctrl #(
  parameter logic [3:0] MODULE_TYPE = 4'h5, // Arbitrary value.
  parameter logic [3:0] REVISION_LEVEL = 4'h1 // Arbitrary value.
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [6:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SIN,
  input wire logic IRRX,
  input wire logic DSR_N,
  input wire logic CTS_N,
  input wire logic RI_N,
  input wire logic DCD_N,
  input wire logic CORE_TXD,
  input wire logic CORE_IRTX,
  input wire logic TX_PUSH,
  input wire logic TX_POP,
  input wire logic RX_PUSH,
  input wire logic RX_POP,
  output logic SOUT,
  output logic IRTX,
  output logic DTR_N,
  output logic RTS_N,
  output logic CORE_RXD,
  output logic CORE_IRRX,
  output logic [3:0] MODEM_STATUS,
  output logic EXT_MODE,
  output logic [7:0] LINE_CTRL,
  output logic [15:0] BAUD_DIVISOR,
  output logic BAUD_TICK
);

  uart_ext_pkg::state_s s_reg;
  uart_ext_pkg::state_s s_next;

  logic [1:0] bank;
  logic [2:0] idx;
  logic access_first;
  logic access_done;
  logic legacy_port;
  logic fallback_ok;
  logic do_write;
  logic [7:0] wbyte;
  logic [7:0] rd;
  logic rd_err;
  logic [7:0] ext_one_rd;
  logic [7:0] ext_two_rd;
  logic [7:0] mcr_rd;
  logic [4:0] pre_step;
  logic [4:0] pre_sum;
  logic pre_tick;

  // Bank and register index come straight from the byte address.
  assign bank = PADDR[uart_ext_pkg::BANK_LSB +: 2];
  assign idx = PADDR[uart_ext_pkg::IDX_LSB +: 3];
  assign access_first = PSEL && PENABLE && !s_reg.pready;
  assign access_done = PSEL && PENABLE && s_reg.pready;
  assign wbyte = PWDATA[7:0];
  assign legacy_port = (bank == uart_ext_pkg::BANK1)
    && (idx == uart_ext_pkg::IDX_DIV_LOW || idx == uart_ext_pkg::IDX_DIV_HIGH);
  // Outside extended mode the lock blocks fallback and the divisor path.
  assign fallback_ok = !(s_reg.lock && !s_reg.ext); // RULE13
  assign do_write = access_done && PWRITE && !s_reg.pslverr && PSTRB[0];

  // Read views; reserved positions are tied to zero.
  always_comb
  begin
    ext_one_rd = 8'h00; // RULE11
    ext_one_rd[uart_ext_pkg::EXT_BIT] = s_reg.ext;
    ext_one_rd[uart_ext_pkg::LOOP_BIT] = s_reg.loop;
    ext_one_rd[uart_ext_pkg::ETD_BIT] = s_reg.etd;
    ext_one_rd[uart_ext_pkg::BAUD_GEN_TEST_BIT] = s_reg.baud_gen_test;
    ext_two_rd = 8'h00; // RULE11
    ext_two_rd[uart_ext_pkg::PRESEL_LSB +: 2] = s_reg.presel;
    ext_two_rd[uart_ext_pkg::LOCK_BIT] = s_reg.lock;
    mcr_rd = s_reg.modem_control_reg;
    mcr_rd[uart_ext_pkg::LOOP_BIT] = s_reg.loop; // RULE3
  end

  // Read data multiplexer; an unmapped or misaligned address answers with an error.
  always_comb
  begin
    rd = 8'h00;
    rd_err = 1'b0;
    unique case (bank)
      uart_ext_pkg::BANK0:
      begin
        if (idx == uart_ext_pkg::IDX_LCR)
          rd = s_reg.line_control_reg;
        else if (idx == uart_ext_pkg::IDX_MCR)
          rd = mcr_rd;
        else if (idx != uart_ext_pkg::IDX_FCR)
          rd_err = 1'b1;
      end
      uart_ext_pkg::BANK1:
      begin
        if (idx == uart_ext_pkg::IDX_DIV_LOW)
          rd = fallback_ok ? s_reg.div[7:0] : s_reg.scr_low; // RULE14
        else if (idx == uart_ext_pkg::IDX_DIV_HIGH)
          rd = fallback_ok ? s_reg.div[15:8] : s_reg.scr_high; // RULE14
        else if (idx == uart_ext_pkg::IDX_LCR)
          rd = s_reg.line_control_reg;
        else
          rd_err = 1'b1;
      end
      uart_ext_pkg::BANK2:
      begin
        unique case (idx)
          uart_ext_pkg::IDX_DIV_LOW: rd = s_reg.div[7:0];
          uart_ext_pkg::IDX_DIV_HIGH: rd = s_reg.div[15:8];
          uart_ext_pkg::IDX_EXT_ONE: rd = ext_one_rd;
          uart_ext_pkg::IDX_LCR: rd = s_reg.line_control_reg; // RULE23
          uart_ext_pkg::IDX_EXT_TWO: rd = ext_two_rd;
          uart_ext_pkg::IDX_RSVD: rd = 8'h00; // RULE16
          uart_ext_pkg::IDX_TX_LEVEL: rd = {3'h0, s_reg.tx_lvl}; // RULE17
          uart_ext_pkg::IDX_RX_LEVEL: rd = {3'h0, s_reg.rx_lvl}; // RULE17
        endcase
      end
      uart_ext_pkg::BANK3:
      begin
        if (idx == uart_ext_pkg::IDX_REV)
          rd = {MODULE_TYPE, REVISION_LEVEL}; // RULE20
        else if (idx == uart_ext_pkg::IDX_LCR_SHADOW)
          rd = s_reg.line_control_reg; // RULE21
        else if (idx == uart_ext_pkg::IDX_FCR_SHADOW)
          rd = s_reg.fifo_control_reg; // RULE22
        else if (idx == uart_ext_pkg::IDX_LCR)
          rd = s_reg.line_control_reg; // RULE23
        else
          rd_err = 1'b1;
      end
    endcase
    if (PADDR[1:0] != 2'h0)
      rd_err = 1'b1;
  end

  // Prescaler: a fractional accumulator gives the 13/8 step without a second clock.
  always_comb
  begin
    pre_step = (s_reg.presel == uart_ext_pkg::PRE_1625)
      ? uart_ext_pkg::PRE_STEP_FRAC : uart_ext_pkg::PRE_STEP_INT; // RULE12
    pre_sum = s_reg.pacc + pre_step;
    pre_tick = (s_reg.presel == uart_ext_pkg::PRE_1) || (pre_sum >= uart_ext_pkg::PRE_DEN);
  end

  // Next-state logic for the whole block.
  always_comb
  begin
    s_next = s_reg;
    s_next.btick = 1'b0;
    // One wait state: the first access cycle prepares the answer.
    s_next.pready = access_first;
    if (access_first)
    begin
      s_next.prdata = rd_err ? 32'h00000000 : {24'h000000, rd};
      s_next.pslverr = rd_err;
    end
    else if (access_done)
    begin
      s_next.pslverr = 1'b0;
    end

    // Baud generator; the reserved prescaler code behaves as 13.
    if (s_reg.presel != uart_ext_pkg::PRE_1)
      s_next.pacc = (pre_sum >= uart_ext_pkg::PRE_DEN) ? pre_sum - uart_ext_pkg::PRE_DEN : pre_sum;
    if (pre_tick && s_reg.div != 16'h0000)
    begin
      if (s_reg.bcnt <= 16'h0001)
      begin
        s_next.bcnt = s_reg.div;
        s_next.btick = 1'b1;
        s_next.bout = !s_reg.bout;
      end
      else
      begin
        s_next.bcnt = s_reg.bcnt - 16'h0001;
      end
    end

    // Level counters follow the core's push and pop strobes.
    unique case ({TX_PUSH, TX_POP})
      2'b10: if (s_reg.tx_lvl != uart_ext_pkg::LEVEL_MAX) s_next.tx_lvl = s_reg.tx_lvl + 5'h01; // RULE26
      2'b01: if (s_reg.tx_lvl != 5'h00) s_next.tx_lvl = s_reg.tx_lvl - 5'h01; // RULE26
      default: s_next.tx_lvl = s_reg.tx_lvl;
    endcase
    unique case ({RX_PUSH, RX_POP})
      2'b10: if (s_reg.rx_lvl != uart_ext_pkg::LEVEL_MAX) s_next.rx_lvl = s_reg.rx_lvl + 5'h01; // RULE26
      2'b01: if (s_reg.rx_lvl != 5'h00) s_next.rx_lvl = s_reg.rx_lvl - 5'h01; // RULE26
      default: s_next.rx_lvl = s_reg.rx_lvl;
    endcase

    // Any completed legacy access, read or write, falls back unless locked outside extended mode.
    if (access_done && legacy_port && fallback_ok)
    begin
      if (s_reg.ext)
      begin
        s_next.modem_control_reg[7:2] = 6'h00; // RULE24
        s_next.loop = 1'b0; // RULE24
        s_next.ext = 1'b0; // RULE24
      end
      s_next.etd = 1'b0; // RULE24
      s_next.baud_gen_test = 1'b0; // RULE24
      s_next.presel = uart_ext_pkg::PRE_13; // RULE24
    end

    // Register writes take effect at the completing edge only.
    if (do_write)
    begin
      if (idx == uart_ext_pkg::IDX_LCR)
        s_next.line_control_reg = wbyte; // RULE21
      unique case (bank)
        uart_ext_pkg::BANK0:
        begin
          if (idx == uart_ext_pkg::IDX_FCR)
            s_next.fifo_control_reg = wbyte; // RULE22
          if (idx == uart_ext_pkg::IDX_MCR)
          begin
            s_next.modem_control_reg = wbyte;
            // In extended mode bit 4 of modem control is not the loopback storage.
            if (!s_reg.ext)
              s_next.loop = wbyte[uart_ext_pkg::LOOP_BIT]; // RULE3
          end
        end
        uart_ext_pkg::BANK1:
        begin
          if (legacy_port && !fallback_ok)
          begin
            if (idx == uart_ext_pkg::IDX_DIV_LOW)
              s_next.scr_low = wbyte; // RULE14
            else
              s_next.scr_high = wbyte; // RULE14
          end
          else if (legacy_port)
          begin
            if (idx == uart_ext_pkg::IDX_DIV_LOW)
              s_next.div[7:0] = wbyte;
            else
              s_next.div[15:8] = wbyte;
            s_next.bcnt = (idx == uart_ext_pkg::IDX_DIV_LOW)
              ? {s_reg.div[15:8], wbyte} : {wbyte, s_reg.div[7:0]};
            s_next.pacc = 5'h00;
          end
        end
        uart_ext_pkg::BANK2:
        begin
          // The alternate divisor ports never touch the mode.
          if (idx == uart_ext_pkg::IDX_DIV_LOW)
          begin
            s_next.div[7:0] = wbyte; // RULE25
            s_next.bcnt = {s_reg.div[15:8], wbyte}; // RULE25
            s_next.pacc = 5'h00;
          end
          if (idx == uart_ext_pkg::IDX_DIV_HIGH)
          begin
            s_next.div[15:8] = wbyte; // RULE25
            s_next.bcnt = {wbyte, s_reg.div[7:0]}; // RULE25
            s_next.pacc = 5'h00;
          end
          if (idx == uart_ext_pkg::IDX_EXT_ONE)
          begin
            s_next.ext = wbyte[uart_ext_pkg::EXT_BIT]; // RULE2
            s_next.loop = wbyte[uart_ext_pkg::LOOP_BIT]; // RULE3
            s_next.etd = wbyte[uart_ext_pkg::ETD_BIT]; // RULE9
            s_next.baud_gen_test = wbyte[uart_ext_pkg::BAUD_GEN_TEST_BIT]; // RULE10
          end
          if (idx == uart_ext_pkg::IDX_EXT_TWO)
          begin
            s_next.presel = wbyte[uart_ext_pkg::PRESEL_LSB +: 2]; // RULE12
            s_next.lock = wbyte[uart_ext_pkg::LOCK_BIT]; // RULE13
          end
        end
        uart_ext_pkg::BANK3:
        begin
          s_next.line_control_reg = s_next.line_control_reg; // Only the shared offset 3 is writable here.
        end
      endcase
    end

    // Serial paths: in loopback the receivers hear their own transmitters.
    if (s_reg.loop)
    begin
      s_next.rxd = CORE_TXD; // RULE6
      s_next.irrx = CORE_IRTX; // RULE6
      s_next.sout = s_reg.etd ? CORE_TXD : 1'b1; // RULE7 RULE9
      s_next.irtx = s_reg.etd ? CORE_IRTX : 1'b0; // RULE7 RULE9
    end
    else
    begin
      s_next.rxd = SIN;
      s_next.irrx = IRRX;
      s_next.sout = CORE_TXD;
      s_next.irtx = CORE_IRTX;
    end

    // Modem status order is {DCD, RI, CTS, DSR}, active high toward the core.
    if (s_reg.loop && s_reg.ext)
      s_next.ms = {s_reg.modem_control_reg[1], s_reg.modem_control_reg[0], s_reg.modem_control_reg[1], s_reg.modem_control_reg[0]}; // RULE4 RULE5
    else if (s_reg.loop)
      s_next.ms = {s_reg.modem_control_reg[3], s_reg.modem_control_reg[2], s_reg.modem_control_reg[1], s_reg.modem_control_reg[0]}; // RULE8 RULE5
    else
      s_next.ms = {!DCD_N, !RI_N, !CTS_N, !DSR_N};

    // Test mode puts the baud square wave on the DTR pin.
    s_next.dtr_n = s_reg.baud_gen_test ? s_reg.bout : !s_reg.modem_control_reg[0]; // RULE10
    s_next.rts_n = !s_reg.modem_control_reg[1];
  end

  // State register; reset clears every control field.
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      s_reg <= uart_ext_pkg::STATE_RST; // RULE1 RULE16
    else
      s_reg <= s_next;
  end

  // Ports read the state flip-flops directly; levels are never frozen for a read.
  assign PRDATA = s_reg.prdata; // RULE18
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign SOUT = s_reg.sout;
  assign IRTX = s_reg.irtx;
  assign DTR_N = s_reg.dtr_n;
  assign RTS_N = s_reg.rts_n;
  assign CORE_RXD = s_reg.rxd;
  assign CORE_IRRX = s_reg.irrx;
  assign MODEM_STATUS = s_reg.ms;
  assign EXT_MODE = s_reg.ext;
  assign LINE_CTRL = s_reg.line_control_reg;
  assign BAUD_DIVISOR = s_reg.div;
  assign BAUD_TICK = s_reg.btick;

endmodule : uart_ext_ctrl

// ---- uart_ext_pkg.sv ----
// Constants, register layout and state carrier of the extended serial control block.
// Assumes an APB master; the byte address carries the bank and the register index.
package uart_ext_pkg;

  // Bank number in address bits 6:5, register index in bits 4:2.
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;
  localparam logic [1:0] BANK2 = 2'h2;
  localparam logic [1:0] BANK3 = 2'h3;
  localparam int BANK_LSB = 5;
  localparam int IDX_LSB = 2;

  // Register indices inside a bank.
  localparam logic [2:0] IDX_DIV_LOW = 3'h0;
  localparam logic [2:0] IDX_DIV_HIGH = 3'h1;
  localparam logic [2:0] IDX_REV = 3'h0;
  localparam logic [2:0] IDX_LCR_SHADOW = 3'h1;
  localparam logic [2:0] IDX_FCR = 3'h2;
  localparam logic [2:0] IDX_EXT_ONE = 3'h2;
  localparam logic [2:0] IDX_FCR_SHADOW = 3'h2;
  localparam logic [2:0] IDX_LCR = 3'h3;
  localparam logic [2:0] IDX_MCR = 3'h4;
  localparam logic [2:0] IDX_EXT_TWO = 3'h4;
  localparam logic [2:0] IDX_RSVD = 3'h5;
  localparam logic [2:0] IDX_TX_LEVEL = 3'h6;
  localparam logic [2:0] IDX_RX_LEVEL = 3'h7;

  // Field positions.
  localparam int EXT_BIT = 0;
  localparam int LOOP_BIT = 4;
  localparam int ETD_BIT = 5;
  localparam int BAUD_GEN_TEST_BIT = 7;
  localparam int PRESEL_LSB = 4;
  localparam int LOCK_BIT = 7;

  // Prescaler codes and the fractional step: 1.625 is 13/8.
  localparam logic [1:0] PRE_13 = 2'h0;
  localparam logic [1:0] PRE_1625 = 2'h1;
  localparam logic [1:0] PRE_1 = 2'h3;
  localparam logic [4:0] PRE_DEN = 5'h0D;
  localparam logic [4:0] PRE_STEP_FRAC = 5'h08;
  localparam logic [4:0] PRE_STEP_INT = 5'h01;
  localparam logic [4:0] LEVEL_MAX = 5'h1F;

  typedef struct packed {
    logic ext;
    logic loop;
    logic etd;
    logic baud_gen_test;
    logic lock;
    logic [1:0] presel;
    logic [7:0] modem_control_reg;
    logic [7:0] line_control_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] scr_low;
    logic [7:0] scr_high;
    logic [15:0] div;
    logic [15:0] bcnt;
    logic [4:0] pacc;
    logic bout;
    logic btick;
    logic [4:0] tx_lvl;
    logic [4:0] rx_lvl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sout;
    logic irtx;
    logic dtr_n;
    logic rts_n;
    logic rxd;
    logic irrx;
    logic [3:0] ms;
  } state_s;

  // Idle line and inactive modem pins after reset; everything else zero.
  localparam state_s STATE_RST = '{sout: 1'b1, dtr_n: 1'b1, rts_n: 1'b1, default: '0};

endpackage : uart_ext_pkg

// ---- uart_ext_ctrl_properties.sv ----
// Concurrent checks on the bus and status ports of the extended serial control block.
// Assumes only the block's top ports; bound to every instance of the block.
`timescale 1ns/1ps
module uart_ext_ctrl_properties (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [6:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic EXT_MODE,
  input wire logic [7:0] LINE_CTRL,
  input wire logic [15:0] BAUD_DIVISOR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Steps of a transfer: the first access cycle, then the completing cycle.
  sequence first_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence done(logic [6:0] a, logic w);
    PSEL && PENABLE && PREADY && PWRITE == w && PADDR == a && (!w || PSTRB[0]);
  endsequence

  // The slave answers after exactly one wait state, with a one-cycle pulse.
  a_one_wait: assert property (first_access |=> PREADY ##1 !PREADY)
    else $error("ready is not a single pulse after one wait");
  a_misalign_err: assert property ((first_access and (PADDR[1:0] != 2'h0)) |=> PSLVERR)
    else $error("misaligned access not flagged");
  // Reset must win over everything, so this one is never disabled.
  a_reset_clear: assert property (disable iff (1'b0) RST |=> !EXT_MODE && !PREADY)
    else $error("reset did not clear mode or ready");
  a_ext_one_rsvd: assert property (done(7'h48, 1'b0) |-> PRDATA[3:1] == 3'h0 && !PRDATA[6])
    else $error("reserved bits of control one read nonzero");
  a_ext_two_rsvd: assert property (done(7'h50, 1'b0) |-> PRDATA[3:0] == 4'h0 && !PRDATA[6])
    else $error("reserved bits of control two read nonzero");
  a_rsvd_zero: assert property (done(7'h54, 1'b0) |-> PRDATA == 32'h0)
    else $error("reserved register read nonzero");
  a_level_upper: assert property (PREADY && !PWRITE && PADDR[6:3] == 4'hB |-> PRDATA[7:5] == 3'h0)
    else $error("level register upper bits nonzero");
  a_fallback: assert property (done(7'h20, 1'b0) ##0 EXT_MODE |=> !EXT_MODE)
    else $error("legacy divisor access kept extended mode");
  a_alt_div: assert property (done(7'h40, 1'b1) |=>
    BAUD_DIVISOR[7:0] == $past(PWDATA[7:0]) && $stable(EXT_MODE))
    else $error("alternate divisor write wrong or changed mode");
  a_lcr_any_bank: assert property (PREADY && PWRITE && PSTRB[0] && PADDR[4:0] == 5'h0C |=>
    LINE_CTRL == $past(PWDATA[7:0]))
    else $error("line control not taken from offset three");
endmodule : uart_ext_ctrl_properties

bind uart_ext_ctrl uart_ext_ctrl_properties i_props (.*);

// ---- uart_ext_peer.sv ----
// Far-side partner: a wired or infrared serial peer plus a modem.
// Assumes the bench sets the level it sends and which modem lines it asserts.
`timescale 1ns/1ps
module uart_ext_peer (
  input wire logic line_bit,
  input wire logic [3:0] status,
  output logic SIN,
  output logic IRRX,
  output logic DSR_N,
  output logic CTS_N,
  output logic RI_N,
  output logic DCD_N
);
  // The infrared line idles opposite to the wire, so both carry the same news.
  assign SIN = line_bit;
  assign IRRX = ~line_bit;
  // Modem lines are active low; status holds {DCD, RI, CTS, DSR} asserted.
  assign {DCD_N, RI_N, CTS_N, DSR_N} = ~status;
endmodule : uart_ext_peer

// ---- uart_ext_ctrl_tb.sv ----
// Self-checking bench of the extended serial control block and its link peer.
// Assumes the checker binds itself to the block; 25 MHz clock, APB host.
`timescale 1ns/1ps
module uart_ext_ctrl_tb;
  localparam logic [3:0] MT = 4'h9; // Arbitrary value.
  localparam logic [3:0] RL = 4'h3; // Arbitrary value.
  logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SIN, IRRX, line_bit;
  logic DSR_N, CTS_N, RI_N, DCD_N, CORE_TXD, CORE_IRTX, TX_PUSH, TX_POP, RX_PUSH, RX_POP;
  logic SOUT, IRTX, DTR_N, RTS_N, CORE_RXD, CORE_IRRX, EXT_MODE, BAUD_TICK;
  logic [6:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] PSTRB, MODEM_STATUS, status;
  logic [7:0] LINE_CTRL;
  logic [15:0] BAUD_DIVISOR;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  uart_ext_ctrl #(.MODULE_TYPE(MT), .REVISION_LEVEL(RL)) i_dut (.*);
  uart_ext_peer i_peer (.*);

  // Inputs start idle with reset high; the clock then runs free.
  initial
  begin
    {RST, PSTRB, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 4'h1, 42'h0};
    {CORE_TXD, CORE_IRTX, TX_PUSH, TX_POP, RX_PUSH, RX_POP, line_bit, status} = '0;
    // The wired transmitter idles high, like a real line between frames.
    CORE_TXD = 1'b1;
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  // A stuck handshake must not hang the run.
  always @(posedge CORE_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One bus transfer, held unchanged until ready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic e);
    int n;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 50);
    // Outputs still show their pre-edge values here, so this is the completing edge.
    if (PREADY !== 1'b1) n_fail++;
    q = PRDATA[7:0];
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // Register write and checked read.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] x, input logic xe);
    logic [7:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    chk($sformatf("data %h", a), 32'(x), 32'(q));
    chk($sformatf("error %h", a), 32'(xe), 32'(e));
  endtask : rd

  // Levels move under a read, so three reads are taken and one is picked.
  task automatic lvl(input logic [6:0] a, input logic [7:0] x);
    logic [7:0] q1, q2, q3;
    logic e;
    apb(1'b0, a, 8'h00, q1, e);
    apb(1'b0, a, 8'h00, q2, e);
    apb(1'b0, a, 8'h00, q3, e);
    chk($sformatf("level %h", a), 32'(x), 32'((q1 === q2) ? q2 : q3));
  endtask : lvl

  // Pins trail their cause by one register stage; look after two edges.
  task automatic settle;
    repeat (2) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask : settle

  // Reset values, identity and the idle wired output.
  task automatic t_reset;
    rd(7'h48, 8'h00, 1'b0);
    rd(7'h50, 8'h00, 1'b0);
    rd(7'h54, 8'h00, 1'b0);
    wr(7'h60, 8'hFF);
    rd(7'h60, {MT, RL}, 1'b0);
    settle();
    chk("sout idle", 32'h1, 32'(SOUT));
    $display("reset test done");
  endtask : t_reset

  // Reserved bits, mode select and refused addresses.
  task automatic t_regs;
    wr(7'h48, 8'hFF);
    rd(7'h48, 8'hB1, 1'b0);
    chk("ext mode", 32'h1, 32'(EXT_MODE));
    // A refused read must return zero even where the aligned register is nonzero.
    rd(7'h49, 8'h00, 1'b1);
    wr(7'h48, 8'h00);
    wr(7'h50, 8'hFF);
    rd(7'h50, 8'hB0, 1'b0);
    wr(7'h50, 8'h00);
    // A write without the low byte strobe is ignored.
    PSTRB <= 4'h0;
    wr(7'h50, 8'h30);
    PSTRB <= 4'h1;
    rd(7'h50, 8'h00, 1'b0);
    rd(7'h14, 8'h00, 1'b1);
    $display("register test done");
  endtask : t_regs

  // Loopback in plain and extended mode, then back to the pins.
  task automatic t_loop;
    status <= 4'h9;
    line_bit <= 1'b1;
    CORE_IRTX <= 1'b1;
    CORE_TXD <= 1'b0;
    wr(7'h10, 8'h16);
    settle();
    chk("status plain", 32'h6, 32'(MODEM_STATUS));
    chk("rts on", 32'h0, 32'(RTS_N));
    chk("sout held", 32'h1, 32'(SOUT));
    chk("irtx held", 32'h0, 32'(IRTX));
    chk("rx from tx", 32'h0, 32'(CORE_RXD));
    chk("irrx from tx", 32'h1, 32'(CORE_IRRX));
    rd(7'h48, 8'h10, 1'b0);
    wr(7'h48, 8'h31);
    settle();
    chk("status cross", 32'hA, 32'(MODEM_STATUS));
    chk("sout live", 32'h0, 32'(SOUT));
    chk("irtx live", 32'h1, 32'(IRTX));
    wr(7'h48, 8'h00);
    wr(7'h10, 8'h00);
    settle();
    chk("status pins", 32'h9, 32'(MODEM_STATUS));
    chk("rts off", 32'h1, 32'(RTS_N));
    chk("rx pin", 32'h1, 32'(CORE_RXD));
    $display("loopback test done");
  endtask : t_loop

  // Alternate divisor keeps the mode; legacy access falls back unless locked.
  task automatic t_fall;
    wr(7'h48, 8'h01);
    wr(7'h50, 8'h30);
    wr(7'h44, 8'h12);
    wr(7'h40, 8'h34);
    rd(7'h48, 8'h01, 1'b0);
    chk("divisor", 32'h1234, 32'(BAUD_DIVISOR));
    rd(7'h20, 8'h34, 1'b0);
    rd(7'h48, 8'h00, 1'b0);
    rd(7'h50, 8'h00, 1'b0);
    wr(7'h50, 8'h80);
    wr(7'h20, 8'h55);
    rd(7'h20, 8'h55, 1'b0);
    rd(7'h50, 8'h80, 1'b0);
    chk("divisor locked", 32'h1234, 32'(BAUD_DIVISOR));
    wr(7'h50, 8'h00);
    wr(7'h24, 8'h07);
    @(negedge CORE_CLK);
    chk("divisor legacy", 32'h0734, 32'(BAUD_DIVISOR));
    $display("fallback test done");
  endtask : t_fall

  // Cycles spanned by eight baud ticks after the first one seen.
  task automatic baud(input logic [7:0] pre, input logic [7:0] dv, input int x);
    int k;
    int n;
    wr(7'h50, pre);
    wr(7'h44, 8'h00);
    wr(7'h40, dv);
    k = 0;
    n = 0;
    while (k < 9 && n < 2000)
    begin
      @(negedge CORE_CLK);
      n += int'(k > 0);
      k += int'(BAUD_TICK === 1'b1);
    end
    chk($sformatf("ticks %h", pre), x, n);
  endtask : baud

  // Every prescaler code, then the baud clock on the terminal-ready pin.
  task automatic t_baud;
    int lo;
    baud(8'h30, 8'h05, 40);
    baud(8'h00, 8'h01, 104);
    baud(8'h10, 8'h08, 104);
    baud(8'h20, 8'h01, 104);
    wr(7'h50, 8'h30);
    wr(7'h40, 8'h02);
    wr(7'h48, 8'h80);
    lo = 0;
    repeat (8)
    begin
      @(negedge CORE_CLK);
      lo += int'(DTR_N === 1'b0);
    end
    chk("dtr baud", 32'h1, 32'(lo > 0));
    wr(7'h48, 8'h00);
    $display("baud test done");
  endtask : t_baud

  // Levels saturate at both ends; shadows follow their sources.
  task automatic t_levels;
    TX_PUSH <= 1'b1;
    repeat (33) @(posedge CORE_CLK);
    TX_POP <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    TX_PUSH <= 1'b0;
    @(posedge CORE_CLK);
    TX_POP <= 1'b0;
    RX_PUSH <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    {RX_PUSH, RX_POP} <= 2'b01;
    repeat (4) @(posedge CORE_CLK);
    RX_POP <= 1'b0;
    lvl(7'h58, 8'h1E);
    lvl(7'h5C, 8'h00);
    wr(7'h08, 8'hC7);
    rd(7'h68, 8'hC7, 1'b0);
    wr(7'h6C, 8'h1B);
    rd(7'h64, 8'h1B, 1'b0);
    wr(7'h4C, 8'h03);
    rd(7'h2C, 8'h03, 1'b0);
    chk("line ctrl", 32'h03, 32'(LINE_CTRL));
    $display("level test done");
  endtask : t_levels

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence: two edges of reset, then each scenario in turn.
  initial
  begin
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    t_reset();
    t_regs();
    t_loop();
    t_fall();
    t_baud();
    t_levels();
    print_verdict();
  end
endmodule : uart_ext_ctrl_tb
